//--- bench/bus_side_model.sv
// far-side shift and bus logic model for the mode control block
// assumes flags come from the bench and one byte takes 8 base ticks
`timescale 1ns/100ps
module bus_side_model (
  // clock and reset
  input  wire logic       hclk, hresetn,
  // from the control block, flags from the bench
  input  wire logic       gear_clock, serial_out_enable, start_stop_gen,
  input  wire logic [3:0] flags,
  // to the control block
  output logic            transfer_done, arbitration_lost, own_address_hit,
  output logic            general_call_seen, last_received_bit, bus_busy,
  // to the bench
  output logic            byte_active, lines_high
);
  logic [2:0] bit_cnt;

  // released lines float high through their pull-ups
  assign lines_high  = !bus_busy;
  // a byte is in flight from its first tick to its last
  assign byte_active = bit_cnt != 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt <= 3'h0;
      transfer_done <= 1'b0;
      bus_busy <= 1'b0;
      {arbitration_lost, own_address_hit, general_call_seen, last_received_bit} <= 4'h0;
    end else begin
      transfer_done <= gear_clock && bit_cnt == 3'h7;
      bit_cnt <= !serial_out_enable ? 3'h0 : bit_cnt + {2'h0, gear_clock};
      bus_busy <= start_stop_gen;
      {arbitration_lost, own_address_hit, general_call_seen, last_received_bit} <= flags;
    end
  end
endmodule

//--- bench/serial_bus_mode_control_assertions.sv
// port-level checker for the serial bus mode control block
// assumes a single clock and a single slave on the bus
`timescale 1ns/100ps
module serial_bus_mode_control_assertions
  import serial_bus_pkg::*;
(
  // bus side
  input wire logic        hclk, hresetn, hsel, hready, hwrite, hreadyout, hresp,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // control side
  input wire logic        transfer_done, serial_out_enable, role_sel, direction_sel,
  input wire logic        start_stop_strobe, interface_reset, gear_clock, serial_bus_irq,
  input wire mode_type    interface_mode_sel
);
  logic wr_ph;
  logic rd_ph;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
    end else begin
      wr_ph <= hsel && hready && htrans[1] && hwrite && haddr[7:2] == 6'h0;
      rd_ph <= hsel && hready && htrans[1] && !hwrite && haddr[7:2] == 6'h0;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stall or error");
  status_read_a: assert property (rd_ph |-> hrdata[31:8] == 24'h0)
    else $error("status upper bits set");
  out_enable_a: assert property (serial_out_enable == (interface_mode_sel inside {MODE_SIO, MODE_I2C}))
    else $error("output enable wrong for mode");
  ctrl_write_a: assert property (wr_ph && hwdata[1:0] != KEY_FIRE |=>
    interface_mode_sel == $past(hwdata[3:2]) && role_sel == $past(hwdata[7])
    && direction_sel == $past(hwdata[6]) && start_stop_strobe) else $error("control write lost");
  pin_clear_a: assert property (wr_ph && hwdata[4] && !transfer_done && hwdata[1:0] != KEY_FIRE
    |=> !serial_bus_irq) else $error("request not cleared");
  pin_keep_a: assert property (wr_ph && !hwdata[4] && serial_bus_irq && hwdata[1:0] != KEY_FIRE
    |=> serial_bus_irq) else $error("request dropped");
  done_sets_a: assert property (transfer_done |=> serial_bus_irq) else $error("request not set");
  strobe_cause_a: assert property (start_stop_strobe |-> $past(wr_ph)) else $error("stray strobe");
  key_fire_a: assert property (interface_reset |-> $past(wr_ph) && $past(hwdata[1:0]) == KEY_FIRE)
    else $error("stray soft reset");
  gear_gap_a: assert property (gear_clock |=> !gear_clock [*3]) else $error("base tick too close");
  gear_off_a: assert property (!serial_out_enable [*2] |=> !gear_clock) else $error("tick in port mode");

  cover property (interface_reset);
  cover property (gear_clock);
  cover property (wr_ph && hwdata[4] && serial_bus_irq);
endmodule

bind serial_bus_mode_control serial_bus_mode_control_assertions checker_i (.*);

//--- bench/serial_bus_mode_control_test.sv
// self-checking bench for the serial bus mode control block
// assumes the far side model and checker are compiled alongside
`timescale 1ns/100ps
module serial_bus_mode_control_test;
  import serial_bus_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  flags;
  logic        transfer_done, arbitration_lost, own_address_hit, general_call_seen, last_received_bit;
  logic        bus_busy, serial_out_enable, direction_sel, role_sel, start_stop_gen, start_stop_strobe;
  logic        interface_reset, gear_clock, serial_bus_irq, irq;
  logic        byte_active, lines_high;
  mode_type    interface_mode_sel;
  wire         hready = hreadyout;
  int          miscompares, checks, n;

  serial_bus_mode_control DUT (.*);
  bus_side_model far_side (.*);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task test_done;
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // master holds each phase until hready is seen high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // one idle edge, so a write is visible on the outputs when the task returns
    @(posedge hclk);
  endtask

  // software side of a control write: a mode change waits for a quiet link
  task ctrl(input logic [31:0] d);
    logic change;
    change = d[3:2] != interface_mode_sel;
    for (int k = 0; k < 300 && change && d[3:2] == MODE_PORT && bus_busy; k++) @(posedge hclk);
    for (int k = 0; k < 300 && change && interface_mode_sel == MODE_PORT && !lines_high; k++) @(posedge hclk);
    for (int k = 0; k < 300 && change && byte_active; k++) @(posedge hclk);
    bus(1, 8'h00, d);
  endtask

  task tick(output int k);
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (gear_clock !== 1'b1 && k < 99);
  endtask

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    #200000;
    miscompares++;
    test_done;
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, flags} = '0;
    hsize = 3'h2;
    seed = 32'h62bfbaa1;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, 8'h00, 0); chk(r, 32'h10);
    bus(0, 8'h04, 0); chk(r, 0);
    for (int m = 0; m < 4; m++) begin
      seed = xs(seed);
      ctrl({24'h0, seed[7:6], 2'h0, m[1:0], 2'h0});
      chk(interface_mode_sel, m);
      chk(serial_out_enable, m == 1 || m == 2);
      chk({role_sel, direction_sel}, seed[7:6]);
      bus(0, 8'h00, 0); chk(r[7:6], seed[7:6]);
    end
    ctrl(32'h08);
    for (int g = 0; g < 4; g++) begin
      bus(1, 8'h04, g);
      tick(n);
      tick(n); chk(n, 4 << g);
    end
    ctrl(32'h00);
    bus(1, 8'h04, 0);
    ctrl(32'h10); chk(serial_bus_irq, 0);
    bus(1, 8'h0c, 32'h1f);
    bus(1, 8'h10, 32'h01); chk(irq, 0);
    // transfer finishes before mode goes back to port
    ctrl(32'h04);
    n = 0;
    while (serial_bus_irq !== 1'b1 && n < 99) begin
      @(posedge hclk);
      n++;
    end
    repeat (2) @(posedge hclk); chk(irq, 1);
    ctrl(32'h00); chk(serial_bus_irq, 1);
    bus(0, 8'h00, 0); chk(r[4], 0);
    bus(1, 8'h00, 32'h10); chk(serial_bus_irq, 0);
    bus(1, 8'h0c, 32'h01);
    repeat (2) @(posedge hclk); chk(irq, 0);
    bus(1, 8'h0c, 32'h1f);
    bus(1, 8'h00, 32'h01);
    bus(1, 8'h00, 32'h02);
    bus(1, 8'h00, 32'h03);
    bus(1, 8'h00, 32'h01);
    bus(0, 8'h08, 0); chk(r[4], 0);
    bus(1, 8'h00, 32'h02);
    bus(1, 8'h00, 32'h01);
    bus(0, 8'h08, 0); chk(r[4], 1);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      flags <= 4'h0;
      bus(1, 8'h00, {26'h0, seed[5], 5'h0}); chk(start_stop_gen, seed[5]);
      bus(1, 8'h0c, 32'h1f);
      flags <= seed[3:0];
      repeat (4) @(posedge hclk);
      bus(0, 8'h00, 0); chk(r, {26'h0, seed[5], 1'b1, seed[3:0]});
      bus(0, 8'h08, 0); chk(r[3:1], {seed[1], seed[2], seed[3]});
    end
    bus(1, 8'h20, 32'hffffffff);
    bus(0, 8'h20, 0); chk(r, 0);
    test_done;
  end
endmodule

//--- rtl/gear_divider.sv
// base clock divider: one-cycle tick every 4, 8, 16 or 32 clocks
// assumes gear changes only while the interface is idle
`timescale 1ns/100ps
module gear_divider
  import serial_bus_pkg::*;
#(
  parameter int CNT_W = DIV_CNT_W
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control side
  gear_link_if.divider link
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             tick;
  } div_state_type;

  div_state_type    state;
  div_state_type    next_state;
  logic [CNT_W-1:0] limit;

  assign link.tick = state.tick;

  always_comb begin
    next_state = state;
    limit = CNT_W'((32'd1 << (DIV_SHIFT_BASE + 32'(link.gear))) - 32'd1);
    next_state.tick = 1'b0;
    if (!link.enable) begin
      next_state.count = '0;
    end else if (state.count >= limit) begin
      next_state.count = '0;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = state.count + CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule

//--- rtl/gear_link_if.sv
// link between the control block and its base clock divider
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface gear_link_if;
  logic [1:0] gear;
  logic       enable;
  logic       tick;

  modport ctrl (output gear, output enable, input tick);
  modport divider (input gear, input enable, output tick);
endinterface

//--- rtl/serial_bus_mode_control.sv
// serial bus mode control: AHB-Lite register slave, mode and role
// selection, soft reset key, request flag, status byte and interrupts
// assumes shift, address match and arbitration logic sit next to it on hclk
`timescale 1ns/100ps
module serial_bus_mode_control
  import serial_bus_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // from adjacent shift and bus logic
  input  wire logic        transfer_done,
  input  wire logic        arbitration_lost,
  input  wire logic        own_address_hit,
  input  wire logic        general_call_seen,
  input  wire logic        last_received_bit,
  input  wire logic        bus_busy,
  // to adjacent shift and bus logic
  output mode_type         interface_mode_sel,
  output logic             serial_out_enable,
  output logic             direction_sel,
  output logic             role_sel,
  output logic             start_stop_gen,
  output logic             start_stop_strobe,
  output logic             interface_reset,
  output logic             gear_clock,
  output logic             serial_bus_irq,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
    mode_type         mode;
    logic             oe;
    logic             dir;
    logic             role;
    logic             ssg;
    logic             ssg_strobe;
    key_state_type    key;
    logic             soft_rst;
    logic [1:0]       gear;
    logic             pending;
    logic [7:0]       status;
    logic [2:0]       flags_prev;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic             irq;
    logic             tick;
  } state_type;

  state_type        state;
  state_type        next_state;
  logic             accept;
  logic [7:0]       ctrl_byte;
  logic [2:0]       flags_now;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clear_mask;

  gear_link_if link ();

  gear_divider #(
    .CNT_W (DIV_CNT_W)
  ) u_gear_divider (
    .hclk    (hclk),
    .hresetn (hresetn),
    .link    (link)
  );

  assign link.gear   = state.gear;
  assign link.enable = state.oe;

  // word offset compare, used by both read and write decode
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
    hits = (addr[7:2] == offset[7:2]);
  endfunction

  // mode values that drive the serial outputs
  function automatic logic mode_drives(input mode_type mode);
    case (mode)
      MODE_SIO: mode_drives = 1'b1;
      MODE_I2C: mode_drives = 1'b1;
      default:  mode_drives = 1'b0;
    endcase
  endfunction

  assign accept = hsel && hready && htrans[1];

  always_comb begin
    next_state = state;
    ctrl_byte  = hwdata[7:0];
    clear_mask = '0;
    flags_now  = {arbitration_lost, own_address_hit, general_call_seen};
    events     = '0;

    next_state.ssg_strobe = 1'b0;
    next_state.soft_rst   = 1'b0;
    next_state.tick       = link.tick;

    // address phase: reads answer in the following data phase
    next_state.wr_pend = accept && hwrite;
    if (accept) begin
      next_state.wr_addr = haddr[7:0];
    end
    if (accept && !hwrite) begin
      next_state.rdata = '0;
      if (hits(haddr[7:0], ADDR_MODE_CTRL)) begin
        next_state.rdata[7:0] = state.status;
      end else if (hits(haddr[7:0], ADDR_GEAR)) begin
        next_state.rdata[1:0] = state.gear;
      end else if (hits(haddr[7:0], ADDR_IRQ_STATUS)) begin
        next_state.rdata[IRQ_W-1:0] = state.irq_status;
      end else if (hits(haddr[7:0], ADDR_IRQ_ENABLE)) begin
        next_state.rdata[IRQ_W-1:0] = state.irq_enable;
      end
    end

    // data phase of a write
    if (state.wr_pend) begin
      if (hits(state.wr_addr, ADDR_MODE_CTRL)) begin
        next_state.mode = mode_type'(ctrl_byte[MODE_LSB +: 2]);
        next_state.dir  = ctrl_byte[DIR_BIT];
        next_state.role = ctrl_byte[ROLE_BIT];
        next_state.ssg        = ctrl_byte[SSG_BIT];
        next_state.ssg_strobe = 1'b1;
        if (ctrl_byte[PIN_BIT]) begin
          next_state.pending = 1'b0;
        end
        case (state.key)
          KEY_IDLE: begin
            if (ctrl_byte[KEY_LSB +: 2] == KEY_ARM) begin
              next_state.key = KEY_ARMED;
            end
          end
          KEY_ARMED: begin
            if (ctrl_byte[KEY_LSB +: 2] == KEY_FIRE) begin
              next_state.key      = KEY_IDLE;
              next_state.soft_rst = 1'b1;
            end else if (ctrl_byte[KEY_LSB +: 2] == KEY_DROP) begin
              next_state.key = KEY_IDLE;
            end
          end
          default: begin
            next_state.key = KEY_IDLE;
          end
        endcase
      end else if (hits(state.wr_addr, ADDR_GEAR)) begin
        next_state.gear = hwdata[1:0];
      end else if (hits(state.wr_addr, ADDR_IRQ_CLEAR)) begin
        clear_mask = hwdata[IRQ_W-1:0];
      end else if (hits(state.wr_addr, ADDR_IRQ_ENABLE)) begin
        next_state.irq_enable = hwdata[IRQ_W-1:0];
      end
    end

    // soft reset returns the interface to idle
    if (next_state.soft_rst) begin
      next_state.mode    = MODE_PORT;
      next_state.dir     = 1'b0;
      next_state.role    = 1'b0;
      next_state.ssg     = 1'b0;
      next_state.pending = 1'b0;
    end

    // set wins over a clear in the same cycle
    if (transfer_done) begin
      next_state.pending = 1'b1;
    end

    events[IRQ_TRANSFER] = transfer_done;
    events[IRQ_ARB]      = flags_now[2] && !state.flags_prev[2];
    events[IRQ_HIT]      = flags_now[1] && !state.flags_prev[1];
    events[IRQ_GCALL]    = flags_now[0] && !state.flags_prev[0];
    events[IRQ_SRST]     = state.soft_rst;
    next_state.flags_prev = flags_now;
    next_state.irq_status = (state.irq_status & ~clear_mask) | events;
    next_state.irq        = |(next_state.irq_status & next_state.irq_enable);

    // port mode and the reserved code keep the outputs off
    next_state.oe = mode_drives(next_state.mode);

    next_state.status = {next_state.role, next_state.dir, bus_busy, !next_state.pending,
                         arbitration_lost, own_address_hit, general_call_seen, last_received_bit};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state            <= '0;
      state.mode       <= MODE_PORT;
      state.key        <= KEY_IDLE;
      state.gear       <= GEAR_RESET;
      state.irq_enable <= IRQ_ENABLE_RESET;
      state.status     <= 8'h10;
    end else begin
      state <= next_state;
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata             = state.rdata;
  assign interface_mode_sel = state.mode;
  assign serial_out_enable  = state.oe;
  assign direction_sel      = state.dir;
  assign role_sel           = state.role;
  assign start_stop_gen     = state.ssg;
  assign start_stop_strobe  = state.ssg_strobe;
  assign interface_reset    = state.soft_rst;
  assign gear_clock         = state.tick;
  assign serial_bus_irq     = state.pending;
  assign irq                = state.irq;

endmodule

//--- rtl/serial_bus_pkg.sv
// constants and types for the serial bus mode control block
// assumes a 32-bit AHB-Lite slave port and a single 250 MHz clock
package serial_bus_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_MODE_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_GEAR       = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;

  // control field positions
  localparam int KEY_LSB  = 0;
  localparam int MODE_LSB = 2;
  localparam int PIN_BIT  = 4;
  localparam int SSG_BIT  = 5;
  localparam int DIR_BIT  = 6;
  localparam int ROLE_BIT = 7;

  // soft reset key patterns
  localparam logic [1:0] KEY_ARM  = 2'h2;
  localparam logic [1:0] KEY_FIRE = 2'h1;
  localparam logic [1:0] KEY_DROP = 2'h3;

  // interrupt status bit positions
  localparam int IRQ_TRANSFER = 0;
  localparam int IRQ_ARB      = 1;
  localparam int IRQ_HIT      = 2;
  localparam int IRQ_GCALL    = 3;
  localparam int IRQ_SRST     = 4;
  localparam int IRQ_W        = 5;

  // reset values
  localparam logic [1:0]       GEAR_RESET       = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 5'h00;

  // base clock divides by 2**(DIV_SHIFT_BASE + gear)
  localparam int DIV_SHIFT_BASE = 2;
  localparam int DIV_CNT_W      = 5;

  typedef enum logic [1:0] {
    MODE_PORT     = 2'b00,
    MODE_SIO      = 2'b01,
    MODE_I2C      = 2'b10,
    MODE_RESERVED = 2'b11
  } mode_type;

  typedef enum logic {
    KEY_IDLE  = 1'b0,
    KEY_ARMED = 1'b1
  } key_state_type;

endpackage
